/* core/uep_endpoint_ctrl.sv */
// Overview of operation
// - Max packet length held as bits 9..3
// - Direction bit: 0 OUT, 1 IN
// - IN mode bit: normal or always toggle
// - OUT mode bit: bulk with PING at high speed, or interrupt
// - Disabled endpoint ignores host tokens
// - Endpoint number 0 to 15 in bits 3..0
// - Auto NAK after each good transaction
// - Short send lets partial FIFO go out
// - Short send clears after short packet sent
// - Short send with empty FIFO sends zero-length
// - Short OUT packet sets NAK unless disabled
// - Auto NAK wins over short disable
// - Toggle state bit readable
// - Set and clear strobes force toggle
// - NAK hold answers NAK, deferred mid-transaction
// - STALL wins, applies from next transaction
// - Clear beats set in same write
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "uep_defs.svh"

module uep_endpoint_ctrl (
    // Clock and reset
    input  logic                   aclk,
    input  logic                   aresetn,
    // AXI4-Lite register bus
    input  logic [`UEP_AXI_AW-1:0] awaddr,
    input  logic                   awvalid,
    output logic                   awready,
    input  logic [31:0]            wdata,
    input  logic [3:0]             wstrb,
    input  logic                   wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  logic                   bready,
    input  logic [`UEP_AXI_AW-1:0] araddr,
    input  logic                   arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  logic                   rready,
    // Serial engine
    input  uep_pkg::uep_link_in_t  li,
    output uep_pkg::uep_link_out_t lo
);

    uep_pkg::uep_wr_t    wr;
    logic                wr_err;
    logic [11:0]         rd_idx;
    logic [7:0]          rd_data;
    logic                rd_err;

    // Configuration
    logic [9:3]          max_len;
    logic                dir_in;
    logic                mode;
    logic                ep_en;
    logic [3:0]          ep_id;
    // Control
    logic                auto_nak;
    logic                short_en;
    logic                rx_dis;
    logic                toggle;
    logic                nak_hold;
    logic                nak_pend;
    logic                stall_hold;
    // Transaction tracking
    uep_pkg::uep_state_t state;
    uep_pkg::uep_rsp_t   rsp_q;

    logic                wr_maxh;
    logic                wr_maxl;
    logic                wr_cfg;
    logic                wr_ctl;
    logic                hit;
    logic                busy;
    logic                xend;
    logic                good;
    logic                flip;
    logic                hw_nak;
    logic                short_sent;

    // Typed reset images, since a bare literal cannot have a field picked out
    localparam logic [7:0] rst_maxh = `UEP_RST_MAXH;
    localparam logic [7:0] rst_maxl = `UEP_RST_MAXL;
    localparam logic [7:0] rst_cfg  = `UEP_RST_CFG;
    localparam logic [7:0] rst_ctl  = `UEP_RST_CTL;

    uep_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr      (wr),
        .wr_err  (wr_err),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Address decode
    assign wr_maxh = wr.en && (wr.idx == `UEP_IDX_MAXH);
    assign wr_maxl = wr.en && (wr.idx == `UEP_IDX_MAXL);
    assign wr_cfg  = wr.en && (wr.idx == `UEP_IDX_CFG);
    assign wr_ctl  = wr.en && (wr.idx == `UEP_IDX_CTL);
    assign wr_err  = (wr.idx < `UEP_IDX_MAXH) || (wr.idx > `UEP_IDX_CTL);

    // Read mux
    always_comb begin
        rd_err  = 1'b0;
        rd_data = 8'h00;
        unique case (rd_idx)
            `UEP_IDX_MAXH: rd_data = {6'h00, max_len[9:8]};
            `UEP_IDX_MAXL: rd_data = {max_len[7:3], 3'h0};
            `UEP_IDX_CFG:  rd_data = {dir_in, mode, ep_en, 1'b0, ep_id};
            `UEP_IDX_SPARE: rd_data = 8'h00;
            `UEP_IDX_CTL:  rd_data = {auto_nak, short_en, rx_dis, toggle,
                                      2'b00, nak_hold, stall_hold};
            default:       rd_err  = 1'b1;
        endcase
    end

    // Max packet length; sizes are software's concern, not checked here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_len <= {rst_maxh[`UEP_MAXH_MSB:0], rst_maxl[7:`UEP_MAXL_LSB]};
        end else begin
            if (wr_maxh) begin
                max_len[9:8] <= wr.data[`UEP_MAXH_MSB:0];
            end
            if (wr_maxl) begin
                max_len[7:3] <= wr.data[7:`UEP_MAXL_LSB];
            end
        end
    end

    // Configuration register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_in <= rst_cfg[`UEP_CFG_DIR];
            mode   <= rst_cfg[`UEP_CFG_MODE];
            ep_en  <= rst_cfg[`UEP_CFG_EN];
            ep_id  <= rst_cfg[`UEP_CFG_ID_MSB:0];
        end else if (wr_cfg) begin
            dir_in <= wr.data[`UEP_CFG_DIR];
            mode   <= wr.data[`UEP_CFG_MODE];
            ep_en  <= wr.data[`UEP_CFG_EN];
            ep_id  <= wr.data[`UEP_CFG_ID_MSB:0];
        end
    end

    // Token match on number, direction and enable
    assign hit  = li.tok && ep_en && (li.tok_id == ep_id) && (li.tok_in == dir_in);
    assign busy = (state == uep_pkg::UEP_BUSY);
    assign xend = busy && li.done;
    assign good = xend && li.ok && (rsp_q == uep_pkg::UEP_RSP_ACK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= uep_pkg::UEP_IDLE;
        end else begin
            unique case (state)
                uep_pkg::UEP_IDLE: begin
                    if (hit) begin
                        state <= uep_pkg::UEP_BUSY;
                    end
                end
                uep_pkg::UEP_BUSY: begin
                    if (li.done) begin
                        state <= uep_pkg::UEP_IDLE;
                    end
                end
            endcase
        end
    end

    // Reply fixed at the token, so a late STALL waits for the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_q <= uep_pkg::UEP_RSP_ACK;
        end else if (hit && !busy) begin
            if (stall_hold) begin
                rsp_q <= uep_pkg::UEP_RSP_STALL;
            end else if (nak_hold) begin
                rsp_q <= uep_pkg::UEP_RSP_NAK;
            end else begin
                rsp_q <= uep_pkg::UEP_RSP_ACK;
            end
        end
    end

    // Hardware NAK requests; auto NAK is not masked by the short disable
    assign hw_nak = good && (auto_nak
                    || (!dir_in && li.short_pkt && !rx_dis));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_nak   <= rst_ctl[`UEP_CTL_AUTO];
            rx_dis     <= rst_ctl[`UEP_CTL_RXDIS];
            stall_hold <= rst_ctl[`UEP_CTL_STALL];
        end else if (wr_ctl) begin
            auto_nak   <= wr.data[`UEP_CTL_AUTO];
            rx_dis     <= wr.data[`UEP_CTL_RXDIS];
            stall_hold <= wr.data[`UEP_CTL_STALL];
        end
    end

    // NAK hold; a set during a transaction waits for its end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nak_hold <= rst_ctl[`UEP_CTL_NAK];
            nak_pend <= 1'b0;
        end else begin
            if (wr_ctl && !wr.data[`UEP_CTL_NAK]) begin
                nak_hold <= 1'b0;
                nak_pend <= 1'b0;
            end else if (wr_ctl && busy && !xend) begin
                nak_pend <= 1'b1;
            end else if (wr_ctl) begin
                nak_hold <= 1'b1;
                nak_pend <= 1'b0;
            end
            // A control write in the done cycle overrides the pending set
            if (xend && nak_pend && !wr_ctl) begin
                nak_hold <= 1'b1;
                nak_pend <= 1'b0;
            end
            // Hardware set wins over a clear in the same cycle
            if (hw_nak) begin
                nak_hold <= 1'b1;
            end
        end
    end

    // Short packet send enable
    assign short_sent = good && dir_in && li.short_pkt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            short_en <= rst_ctl[`UEP_CTL_SHORT];
        end else if (wr_ctl) begin
            short_en <= wr.data[`UEP_CTL_SHORT];
        end else if (short_sent) begin
            short_en <= 1'b0;
        end
    end

    // Always-toggle IN flips on any data phase, else only on success
    assign flip = (dir_in && mode) ? (xend && rsp_q == uep_pkg::UEP_RSP_ACK)
                                   : good;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle <= rst_ctl[`UEP_CTL_TGL];
        end else if (wr_ctl && wr.data[`UEP_CTL_TCLR]) begin
            toggle <= 1'b0;
        end else if (wr_ctl && wr.data[`UEP_CTL_TSET]) begin
            toggle <= 1'b1;
        end else if (flip) begin
            toggle <= !toggle;
        end
    end

    // Outputs to the serial engine
    assign lo.sel        = busy;
    assign lo.rsp        = rsp_q;
    assign lo.pid_odd    = toggle;
    assign lo.short_ok   = short_en && dir_in;
    assign lo.zlp        = short_en && dir_in && li.fifo_empty;
    // PING exists only at high speed, as reported by the link
    assign lo.ping       = !dir_in && !mode && li.hs;
    assign lo.always_tgl = dir_in && mode;
    assign lo.max_len    = {max_len, 3'h0};

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ign_disabled_a: assert property (!busy && li.tok && !ep_en |=> !busy)
        else $error("disabled endpoint took a token");
    stall_first_a: assert property (!busy && hit && stall_hold
        |=> lo.rsp == uep_pkg::UEP_RSP_STALL && lo.sel)
        else $error("stall not answered");
    nak_reply_a: assert property (!busy && hit && nak_hold && !stall_hold
        |=> lo.rsp == uep_pkg::UEP_RSP_NAK)
        else $error("nak hold not answered");
    take_ack_a: assert property (!busy && hit && !nak_hold && !stall_hold
        |=> lo.sel && lo.rsp == uep_pkg::UEP_RSP_ACK)
        else $error("matched token not acknowledged");
    stall_late_a: assert property (busy && wr_ctl && wr.data[0] && !xend
        |=> $stable(lo.rsp))
        else $error("stall changed current reply");
    auto_nak_a: assert property (good && auto_nak |=> nak_hold)
        else $error("auto nak missing");
    short_rx_a: assert property (good && !dir_in && li.short_pkt && !rx_dis
        |=> nak_hold)
        else $error("short rx nak missing");
    nak_defer_a: assert property (busy && !xend && !nak_hold && !hw_nak && wr_ctl
        && wr.data[1] ##1 (busy && !li.done) [*2] |-> !nak_hold)
        else $error("nak set inside transaction");
    short_clr_a: assert property (short_sent && !wr_ctl |=> !short_en)
        else $error("short enable not cleared");
    short_keep_a: assert property (good && dir_in && !li.short_pkt && short_en
        && !wr_ctl |=> short_en)
        else $error("short enable wrongly cleared");
    tog_clr_a: assert property (wr_ctl && wr.data[3] && wr.data[2] |=> !toggle)
        else $error("toggle clear lost");
    tog_set_a: assert property (wr_ctl && wr.data[3] && !wr.data[2] |=> toggle)
        else $error("toggle set lost");
    tog_flip_a: assert property (good && !wr_ctl && !(dir_in && mode)
        |=> toggle != $past(toggle))
        else $error("toggle did not advance");

    cov_in_short_c: cover property (short_sent);
    cov_zlp_c: cover property (lo.zlp && hit);
    cov_stall_c: cover property (hit ##1 lo.rsp == uep_pkg::UEP_RSP_STALL);
    cov_defer_c: cover property (nak_pend ##1 nak_hold);

endmodule

/* core/uep_defs.svh */
`ifndef UEP_DEFS_SVH
`define UEP_DEFS_SVH

// Register indices; byte address is four times the index
`define UEP_IDX_MAXH   12'h130
`define UEP_IDX_MAXL   12'h131
`define UEP_IDX_CFG    12'h132
`define UEP_IDX_SPARE  12'h133
`define UEP_IDX_CTL    12'h134

// AXI4-Lite byte address width
`define UEP_AXI_AW     14

// Field positions
`define UEP_MAXH_MSB   1
`define UEP_MAXL_LSB   3
`define UEP_CFG_DIR    7
`define UEP_CFG_MODE   6
`define UEP_CFG_EN     5
`define UEP_CFG_ID_MSB 3
`define UEP_CTL_AUTO   7
`define UEP_CTL_SHORT  6
`define UEP_CTL_RXDIS  5
`define UEP_CTL_TGL    4
`define UEP_CTL_TSET   3
`define UEP_CTL_TCLR   2
`define UEP_CTL_NAK    1
`define UEP_CTL_STALL  0

// Reset values
`define UEP_RST_MAXH   8'h00
`define UEP_RST_MAXL   8'h00
`define UEP_RST_CFG    8'h00
`define UEP_RST_CTL    8'h00

// AXI responses
`define UEP_RESP_OKAY   2'h0
`define UEP_RESP_SLVERR 2'h2

`endif

/* core/uep_pkg.sv */
package uep_pkg;

    typedef enum logic [1:0] {
        UEP_RSP_ACK,
        UEP_RSP_NAK,
        UEP_RSP_STALL
    } uep_rsp_t;

    typedef enum logic {
        UEP_IDLE,
        UEP_BUSY
    } uep_state_t;

    // From the serial engine
    typedef struct packed {
        logic       tok;
        logic [3:0] tok_id;
        logic       tok_in;
        logic       done;
        logic       ok;
        logic       short_pkt;
        logic       fifo_empty;
        logic       hs;
    } uep_link_in_t;

    // To the serial engine
    typedef struct packed {
        logic       sel;
        uep_rsp_t   rsp;
        logic       pid_odd;
        logic       zlp;
        logic       short_ok;
        logic       ping;
        logic       always_tgl;
        logic [9:0] max_len;
    } uep_link_out_t;

    // One register write
    typedef struct packed {
        logic        en;
        logic [11:0] idx;
        logic [7:0]  data;
    } uep_wr_t;

endpackage

/* core/uep_axil_slave.sv */
`timescale 1ns/1ps
`include "uep_defs.svh"

module uep_axil_slave (
    // Clock and reset
    input  logic                   aclk,
    input  logic                   aresetn,
    // AXI4-Lite
    input  logic [`UEP_AXI_AW-1:0] awaddr,
    input  logic                   awvalid,
    output logic                   awready,
    input  logic [31:0]            wdata,
    input  logic [3:0]             wstrb,
    input  logic                   wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  logic                   bready,
    input  logic [`UEP_AXI_AW-1:0] araddr,
    input  logic                   arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  logic                   rready,
    // Register side
    output uep_pkg::uep_wr_t       wr,
    input  logic                   wr_err,
    output logic [11:0]            rd_idx,
    input  logic [7:0]             rd_data,
    input  logic                   rd_err
);

    logic                   aw_full;
    logic                   w_full;
    logic [`UEP_AXI_AW-1:0] aw_q;
    logic [7:0]             w_q;
    logic                   s_q;
    logic                   fire;

    assign awready = !aw_full;
    assign wready  = !w_full;
    assign arready = !rvalid;
    assign rd_idx  = araddr[`UEP_AXI_AW-1:2];
    // Both halves held and no response pending
    assign fire    = aw_full && w_full && !bvalid;
    assign wr.en   = fire && s_q;
    assign wr.idx  = aw_q[`UEP_AXI_AW-1:2];
    assign wr.data = w_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_q    <= '0;
        end else if (awvalid && awready) begin
            aw_full <= 1'b1;
            aw_q    <= awaddr;
        end else if (fire) begin
            aw_full <= 1'b0;
        end
    end

    // Only the low lane holds register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_q    <= 8'h00;
            s_q    <= 1'b0;
        end else if (wvalid && wready) begin
            w_full <= 1'b1;
            w_q    <= wdata[7:0];
            s_q    <= wstrb[0];
        end else if (fire) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `UEP_RESP_OKAY;
        end else if (fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? `UEP_RESP_SLVERR : `UEP_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `UEP_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_data};
            rresp  <= rd_err ? `UEP_RESP_SLVERR : `UEP_RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

/* bench/uep_host_model.sv */
`timescale 1ns/1ps

module uep_host_model (
    // Clock
    input  logic                   aclk,
    // Far-side levels
    input  logic                   fe,
    input  logic                   hs,
    // Endpoint link
    input  uep_pkg::uep_link_out_t lo,
    output uep_pkg::uep_link_in_t  li
);
    logic       tok = 1'b0;
    logic       tin = 1'b0;
    logic       dn  = 1'b0;
    logic       okr = 1'b0;
    logic       sp  = 1'b0;
    logic [3:0] tid = 4'h0;

    assign li = {tok, tid, tin, dn, okr, sp, fe, hs};

    // One token, then done only while the endpoint has it
    task automatic xfer(input logic [3:0] id, input logic in_t, input logic ok_i, input logic sh,
                        input int dly, output logic [2:0] res);
        @(posedge aclk);
        tok <= 1'b1;
        tid <= id;
        tin <= in_t;
        @(posedge aclk);
        tok <= 1'b0;
        tid <= ~id; // Stale lines flip so nothing leans on them
        tin <= ~in_t;
        @(posedge aclk);
        res = {lo.sel, lo.rsp};
        if (lo.sel) begin
            repeat (dly) @(posedge aclk);
            dn  <= 1'b1;
            okr <= ok_i;
            sp  <= sh & ok_i & (lo.rsp == uep_pkg::UEP_RSP_ACK); // No data moves on NAK or STALL
            @(posedge aclk);
            dn  <= 1'b0;
            okr <= ~ok_i;
            sp  <= 1'b0;
        end
    endtask
endmodule

/* bench/usb_device_bulk_int_endpoint_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "uep_defs.svh"

module usb_device_bulk_int_endpoint_ctrl_tb_top;
    logic                   aclk    = 1'b0;
    logic                   aresetn = 1'b0;
    logic [`UEP_AXI_AW-1:0] awaddr  = '0;
    logic [`UEP_AXI_AW-1:0] araddr  = '0;
    logic                   awvalid = 1'b0;
    logic                   wvalid  = 1'b0;
    logic                   bready  = 1'b0;
    logic                   arvalid = 1'b0;
    logic                   rready  = 1'b0;
    logic                   fe      = 1'b0;
    logic                   hs      = 1'b0;
    logic [31:0]            wdata   = '0;
    logic [3:0]             wstrb   = 4'hF;
    logic                   awready, wready, bvalid, arready, rvalid;
    logic [1:0]             bresp, rresp;
    logic [31:0]            rdata;
    logic [2:0]             res;
    uep_pkg::uep_link_in_t  li;
    uep_pkg::uep_link_out_t lo;
    int                     error_cnt = 0;
    int                     check_count = 0;
    int                     cyc = 0;
    int                     ml, dir, md, en, id, au, sh, rx, tg, nk, st, r, cid, cin, ok, sp, hv, fv;

    always #4 aclk = ~aclk;

    uep_endpoint_ctrl dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .li(li), .lo(lo)
    );

    uep_host_model host_u (.aclk(aclk), .fe(fe), .hs(hs), .lo(lo), .li(li));

    task summarize;
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic wr(input logic [11:0] idx, input logic [7:0] v, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'($urandom), v}; // Upper bits must be ignored
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid === 1'b1));
        bready <= 1'b0;
        check_count++;
        if (bresp !== er) begin
            error_cnt++;
            $display("unexpected %0t write %h resp %h", $time, idx, bresp);
        end
    endtask

    task automatic cmp_rd(input logic [11:0] idx, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid === 1'b1));
        rready <= 1'b0;
        check_count++;
        if (rdata !== {24'h0, e} || rresp !== er) begin
            error_cnt++;
            $display("unexpected %0t read %h got %h want %h", $time, idx, rdata, e);
        end
    endtask

    task automatic cmp_lk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %0t link %h want %h", $time, g, e);
        end
    endtask

    task automatic wctl(input logic [7:0] v);
        wr(`UEP_IDX_CTL, v, `UEP_RESP_OKAY);
        au = v[7];
        sh = v[6];
        rx = v[5];
        nk = v[1];
        st = v[0];
        if (v[2]) tg = 0;
        else if (v[3]) tg = 1;
    endtask

    task automatic chk_all;
        cmp_rd(`UEP_IDX_MAXH, 8'(ml >> 5), `UEP_RESP_OKAY);
        cmp_rd(`UEP_IDX_MAXL, 8'((ml & 31) << 3), `UEP_RESP_OKAY);
        cmp_rd(`UEP_IDX_CFG, 8'(dir * 128 + md * 64 + en * 32 + id), `UEP_RESP_OKAY);
        cmp_rd(`UEP_IDX_CTL, 8'(au * 128 + sh * 64 + rx * 32 + tg * 16 + nk * 2 + st), `UEP_RESP_OKAY);
        #1;
        cmp_lk({1'b0, lo.zlp, lo.short_ok, lo.ping, lo.always_tgl, lo.pid_odd, lo.max_len},
               {1'b0, 1'(sh & dir & fv), 1'(sh & dir), 1'(!dir & !md & hv), 1'(dir & md), 1'(tg),
                10'(ml * 8)});
    endtask

    initial begin
        logic [7:0] v;
        static logic [7:0] tv [5] = '{8'h08, 8'h0C, 8'h08, 8'h04, 8'h18};
        r = $urandom(46);
        {ml, dir, md, en, id, au, sh, rx, tg, nk, st, hv, fv} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_all();
        cmp_rd(12'h12F, 8'h00, `UEP_RESP_SLVERR);
        wr(12'h135, 8'hFF, `UEP_RESP_SLVERR);
        wr(`UEP_IDX_SPARE, 8'hFF, `UEP_RESP_OKAY);
        cmp_rd(`UEP_IDX_SPARE, 8'h00, `UEP_RESP_OKAY);
        wstrb <= 4'hE;
        wr(`UEP_IDX_CFG, 8'hFF, `UEP_RESP_OKAY);
        wstrb <= 4'hF;
        chk_all();
        foreach (tv[i]) begin
            wctl(tv[i]);
            chk_all();
        end
        repeat (80) begin
            hv = $urandom % 2;
            fv = $urandom % 2;
            hs <= 1'(hv);
            fe <= 1'(fv);
            ml = 1 << ($urandom % 4);
            if (hv && $urandom % 2) ml = 64;
            dir = $urandom % 2;
            md = $urandom % 2;
            en = ($urandom % 4 != 0);
            id = 1 + $urandom % 15;
            wr(`UEP_IDX_MAXH, 8'(ml >> 5), `UEP_RESP_OKAY);
            wr(`UEP_IDX_MAXL, 8'(((ml & 31) << 3) | ($urandom % 8)), `UEP_RESP_OKAY);
            wr(`UEP_IDX_CFG, 8'(dir * 128 + md * 64 + en * 32 + ($urandom % 2) * 16 + id), `UEP_RESP_OKAY);
            v = 8'($urandom);
            v[1] = ($urandom % 4 == 0);
            v[0] = ($urandom % 6 == 0);
            wctl(v);
            chk_all();
            cid = ($urandom % 4 == 0) ? $urandom % 16 : id;
            cin = ($urandom % 5 == 0) ? !dir : dir;
            ok = ($urandom % 5 != 0);
            sp = $urandom % 2;
            if (cin && fv && sh) sp = 1; // Empty FIFO with short send goes out as zero length
            host_u.xfer(4'(cid), 1'(cin), 1'(ok), 1'(sp), $urandom % 4, res);
            if (en && cid == id && cin == dir) begin
                r = st ? 2 : (nk ? 1 : 0);
                cmp_lk({13'h0, res}, {13'h0, 1'b1, 2'(r)});
                if (r == 0 && (ok || md && dir)) tg ^= 1;
                if (r == 0 && ok) begin
                    if (au || (!dir && sp && !rx)) nk = 1;
                    if (dir && sp) sh = 0;
                end
            end else begin
                cmp_lk(16'(res[2]), 16'h0);
            end
        end
        chk_all();
        summarize();
    end
endmodule
